// [core/epl_ahb_slave.sv]
// ahb-lite slave: zero wait states, always okay, read data registered
// assumes hready is the single slave's hreadyout
`timescale 1ns/1ps
`default_nettype none
module epl_ahb_slave
(
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   // register side
   epl_reg_if.slave_side    regs
);
   logic       wr_pend_q;
   logic [7:0] wr_addr_q;
   logic       take;

   // hsize is not checked; every access is treated as a whole word
   assign take      = hsel && htrans[1] && hready;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign regs.raddr = haddr[7:0];
   assign regs.we    = wr_pend_q;
   assign regs.waddr = wr_addr_q;
   assign regs.wdata = hwdata;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end
      else
      begin
         wr_pend_q <= take && hwrite;
         if (take)
            wr_addr_q <= haddr[7:0];
      end
   end

   // read data sampled at the address phase, stands in the data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (take && !hwrite)
         hrdata <= (haddr[31:8] == 24'h00_0000) ? regs.rdata : 32'h0000_0000;
   end
endmodule
`default_nettype wire

// [core/epl_eprom_lock.sv]
// code store with program, encrypted verify and identification read over pins
// assumes an external programmer on the pins and software on an ahb-lite bus
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - a 64-byte encryption store, all ones while unprogrammed
// - six address lines pick the encryption byte on verify
// - verify output is xnor of encryption byte and code byte
// - 13-bit address on low port plus five high lines; byte data pins
// - no direct read path exists for the encryption store
// - four read-only identification bytes at 30h, 31h, 60h, 61h
// - erase sets every code and encryption cell to one
module epl_eprom_lock #(
   // arbitrary identification values
   parameter logic [7:0] ID_BYTE0 = 8'h11,
   parameter logic [7:0] ID_BYTE1 = 8'h22,
   parameter logic [7:0] ID_BYTE2 = 8'h33,
   parameter logic [7:0] ID_REV   = 8'h01
)
(
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   // programming control pins
   input  wire logic        reset_pin,
   input  wire logic        store_enable_n,
   input  wire logic        program_strobe,
   input  wire logic        vpp_select,
   input  wire logic        vpp_high,
   input  wire logic        select_line_six,
   input  wire logic        select_line_seven,
   input  wire logic        mode_a,
   input  wire logic        mode_b,
   input  wire logic        mode_c,
   // address pins
   input  wire logic [7:0]  low_address_port,
   input  wire logic [4:0]  high_address_lines,
   // data pins
   input  wire logic [7:0]  data_port_i,
   output logic      [7:0]  data_port_o,
   output logic             data_port_oe
);
   epl_reg_if regs ();

   logic [epl_pkg::PIN_W-1:0]  pin_raw;
   logic [epl_pkg::PIN_W-1:0]  pin_lvl;
   logic                       rst_s;
   logic                       store_enable_n_n_s;
   logic                       strobe_s;
   logic                       vsel_s;
   logic                       vhigh_s;
   logic                       sel6_s;
   logic                       sel7_s;
   logic                       ma_s;
   logic                       mb_s;
   logic                       mc_s;
   logic [epl_pkg::ADDR_W-1:0] byte_address;
   logic [epl_pkg::DATA_W-1:0] byte_data;
   logic [epl_pkg::ENC_IDX_W-1:0] enc_idx;

   // both stores are flip-flops indexed by byte address or key index
   logic [7:0] code_q [epl_pkg::CODE_DEPTH];
   logic [7:0] enc_q  [epl_pkg::ENC_DEPTH];

   epl_pkg::epl_mode_t mode;
   logic       common;
   logic       strobe_prev_q;
   logic       prog_pulse;
   logic [2:0] pulse_cnt_q;
   logic [12:0] last_addr_q;
   logic [7:0] last_data_q;
   logic       pin_en_q;
   logic       erase;
   logic [7:0] verify_byte;
   logic [7:0] sig_byte;

   assign pin_raw = {reset_pin, store_enable_n, program_strobe, vpp_select, vpp_high,
                     select_line_six, select_line_seven, mode_a, mode_b, mode_c,
                     high_address_lines, low_address_port, data_port_i};

   epl_pin_sync #(
      .W (epl_pkg::PIN_W)
   ) u_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .pin_i   (pin_raw),
      .lvl_q   (pin_lvl)
   );

   epl_ahb_slave u_bus (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .hrdata    (hrdata),
      .regs      (regs)
   );

   // settled pin levels by name
   assign rst_s        = pin_lvl[30];
   assign store_enable_n_n_s     = pin_lvl[29];
   assign strobe_s     = pin_lvl[28];
   assign vsel_s       = pin_lvl[27];
   assign vhigh_s      = pin_lvl[26];
   assign sel6_s       = pin_lvl[25];
   assign sel7_s       = pin_lvl[24];
   assign ma_s         = pin_lvl[23];
   assign mb_s         = pin_lvl[22];
   assign mc_s         = pin_lvl[21];
   assign byte_address = pin_lvl[20:8];
   assign byte_data    = pin_lvl[7:0];
   assign enc_idx      = byte_address[epl_pkg::ENC_IDX_W-1:0];

   // mode decode from settled pin levels
   assign common = pin_en_q && rst_s && !store_enable_n_n_s && !sel6_s;

   always_comb
   begin
      mode = epl_pkg::EPL_IDLE;
      if (common && sel7_s && ma_s && mb_s && mc_s && vhigh_s)
         mode = epl_pkg::EPL_PROG_CODE;
      else if (common && sel7_s && ma_s && !mb_s && mc_s && vhigh_s)
         mode = epl_pkg::EPL_PROG_ENC;
      else if (common && strobe_s && vsel_s && !vhigh_s && !ma_s && mb_s && mc_s)
         mode = epl_pkg::EPL_VERIFY;
      else if (common && strobe_s && vsel_s && !vhigh_s && !ma_s && !mb_s && !mc_s)
         mode = epl_pkg::EPL_SIGNATURE;
   end

   // a program pulse is a falling edge of the strobe in a program mode
   assign prog_pulse = strobe_prev_q && !strobe_s &&
                       (mode == epl_pkg::EPL_PROG_CODE || mode == epl_pkg::EPL_PROG_ENC);

   assign erase = regs.we && (regs.waddr == epl_pkg::REG_CTRL) &&
                  regs.wdata[epl_pkg::CTRL_ERASE];

   // reset matches the synchroniser's reset level, so reset makes no false strobe edge
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         strobe_prev_q <= 1'b0;
      else
         strobe_prev_q <= strobe_s;
   end

   // pulse count per byte; restarts on a new address or outside program modes
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         pulse_cnt_q <= 3'h0;
      else if (mode != epl_pkg::EPL_PROG_CODE && mode != epl_pkg::EPL_PROG_ENC)
         pulse_cnt_q <= 3'h0;
      else if (prog_pulse)
      begin
         if (byte_address != last_addr_q || pulse_cnt_q == 3'h0)
            pulse_cnt_q <= 3'h1;
         else if (pulse_cnt_q != 3'h7)
            pulse_cnt_q <= pulse_cnt_q + 3'h1;
      end
   end

   // last programmed location for software; a key byte never shows here
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         last_addr_q <= 13'h0000;
         last_data_q <= 8'h00;
      end
      else if (prog_pulse)
      begin
         last_addr_q <= byte_address;
         if (mode == epl_pkg::EPL_PROG_ENC)
            last_data_q <= epl_pkg::ERASED;
         else
            last_data_q <= byte_data;
      end
   end

   // cells only go from one to zero on programming; erase restores ones
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int i = 0; i < epl_pkg::CODE_DEPTH; i++)
            code_q[i] <= epl_pkg::ERASED;
      end
      else if (erase)
      begin
         for (int i = 0; i < epl_pkg::CODE_DEPTH; i++)
            code_q[i] <= epl_pkg::ERASED;
      end
      else if (prog_pulse && mode == epl_pkg::EPL_PROG_CODE)
         code_q[byte_address] <= code_q[byte_address] & byte_data;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int i = 0; i < epl_pkg::ENC_DEPTH; i++)
            enc_q[i] <= epl_pkg::ERASED;
      end
      else if (erase)
      begin
         for (int i = 0; i < epl_pkg::ENC_DEPTH; i++)
            enc_q[i] <= epl_pkg::ERASED;
      end
      else if (prog_pulse && mode == epl_pkg::EPL_PROG_ENC)
         enc_q[enc_idx] <= enc_q[enc_idx] & byte_data;
   end

   // encryption bytes reach the pins only mixed with code
   assign verify_byte = ~(enc_q[enc_idx] ^ code_q[byte_address]);

   // identification bytes; other locations read as erased
   always_comb
   begin
      if (byte_address == epl_pkg::SIG_LOC0)
         sig_byte = ID_BYTE0;
      else if (byte_address == epl_pkg::SIG_LOC1)
         sig_byte = ID_BYTE1;
      else if (byte_address == epl_pkg::SIG_LOC2)
         sig_byte = ID_BYTE2;
      else if (byte_address == epl_pkg::SIG_LOC3)
         sig_byte = ID_REV;
      else
         sig_byte = epl_pkg::ERASED;
   end

   // data pins driven while select seven is low in a read mode
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         data_port_o  <= 8'h00;
         data_port_oe <= 1'b0;
      end
      else
      begin
         data_port_oe <= !sel7_s && (mode == epl_pkg::EPL_VERIFY ||
                                     mode == epl_pkg::EPL_SIGNATURE);
         if (mode == epl_pkg::EPL_SIGNATURE)
            data_port_o <= sig_byte;
         else
            data_port_o <= verify_byte;
      end
   end

   // software control of pin access
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         pin_en_q <= epl_pkg::PIN_EN_RESET;
      else if (regs.we && regs.waddr == epl_pkg::REG_CTRL)
         pin_en_q <= regs.wdata[epl_pkg::CTRL_PIN_EN];
   end

   // register read decode, combinational from the bus address
   always_comb
   begin
      regs.rdata = 32'h0000_0000;
      if (regs.raddr == epl_pkg::REG_CTRL)
         regs.rdata[epl_pkg::CTRL_PIN_EN] = pin_en_q;
      else if (regs.raddr == epl_pkg::REG_STATUS)
      begin
         regs.rdata[epl_pkg::ST_MODE_LSB +: 3] = mode;
         regs.rdata[epl_pkg::ST_CNT_LSB +: 3]  = pulse_cnt_q;
         regs.rdata[epl_pkg::ST_DONE]          = (pulse_cnt_q >= epl_pkg::PROG_PULSES);
      end
      else if (regs.raddr == epl_pkg::REG_LAST)
         regs.rdata[20:0] = {last_data_q, last_addr_q};
      else if (regs.raddr == epl_pkg::REG_REV)
         regs.rdata[7:0] = ID_REV;
   end
endmodule
`default_nettype wire

// [core/epl_pin_sync.sv]
// three-stage synchroniser for asynchronous pins
// a bit changes once the second and third stages agree
`timescale 1ns/1ps
`default_nettype none
module epl_pin_sync #(
   parameter int unsigned W = 1
)
(
   // clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   // pins in, settled levels out
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] lvl_q
);
   genvar g;
   generate
      for (g = 0; g < W; g++)
      begin : g_bit
         logic s1_q;
         logic s2_q;
         logic s3_q;
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
            begin
               s1_q     <= 1'b0;
               s2_q     <= 1'b0;
               s3_q     <= 1'b0;
               lvl_q[g] <= 1'b0;
            end
            else
            begin
               s1_q <= pin_i[g];
               s2_q <= s1_q;
               s3_q <= s2_q;
               if (s2_q == s3_q)
                  lvl_q[g] <= s3_q;
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// [core/epl_pkg.sv]
// constants for the code store access block: geometry, pin modes, register map
// assumes a 32-bit ahb-lite register bus and byte-wide programming pins
`default_nettype none
package epl_pkg;
   // store geometry
   localparam int unsigned ADDR_W     = 13;
   localparam int unsigned DATA_W     = 8;
   localparam int unsigned CODE_DEPTH = 8192;
   localparam int unsigned ENC_DEPTH  = 64;
   localparam int unsigned ENC_IDX_W  = 6;
   localparam logic [7:0]  ERASED     = 8'hff;

   // identification locations
   localparam logic [12:0] SIG_LOC0 = 13'h0030;
   localparam logic [12:0] SIG_LOC1 = 13'h0031;
   localparam logic [12:0] SIG_LOC2 = 13'h0060;
   localparam logic [12:0] SIG_LOC3 = 13'h0061;

   // program pulses per byte
   localparam logic [2:0] PROG_PULSES = 3'h5;

   // synchronised pin vector layout
   localparam int unsigned PIN_W = 31;

   // register byte offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_LAST   = 8'h08;
   localparam logic [7:0] REG_REV    = 8'h0c;

   // field positions
   localparam int unsigned CTRL_ERASE   = 0;
   localparam int unsigned CTRL_PIN_EN  = 1;
   localparam int unsigned ST_MODE_LSB  = 0;
   localparam int unsigned ST_CNT_LSB   = 4;
   localparam int unsigned ST_DONE      = 7;
   localparam logic        PIN_EN_RESET = 1'b1;

   typedef enum logic [2:0] {
      EPL_IDLE,
      EPL_PROG_CODE,
      EPL_PROG_ENC,
      EPL_VERIFY,
      EPL_SIGNATURE
   } epl_mode_t;
endpackage
`default_nettype wire

// [core/epl_reg_if.sv]
// register access carrier between the bus slave and the store core
// assumes one clock; read is combinational from raddr, write is a one-cycle strobe
`timescale 1ns/1ps
`default_nettype none
interface epl_reg_if;
   logic [7:0]  raddr;
   logic [31:0] rdata;
   logic        we;
   logic [7:0]  waddr;
   logic [31:0] wdata;

   modport slave_side
   (
      output raddr,
      input  rdata,
      output we,
      output waddr,
      output wdata
   );

   modport core_side
   (
      input  raddr,
      output rdata,
      input  we,
      input  waddr,
      input  wdata
   );
endinterface
`default_nettype wire

// [dv/epl_eprom_lock_asserts.sv]
// checker on the store block's top ports, bound at the foot of this file
// assumes pin access stays enabled while the pins hold a read mode
`timescale 1ns/1ps
`default_nettype none
module epl_chk #(
   parameter logic [7:0] ID_BYTE0 = 8'h11,
   parameter logic [7:0] ID_BYTE1 = 8'h22,
   parameter logic [7:0] ID_BYTE2 = 8'h33,
   parameter logic [7:0] ID_REV   = 8'h01
)
(
   // clock, reset, bus answer
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic       hreadyout,
   input wire logic       hresp,
   // programming pins
   input wire logic       reset_pin,
   input wire logic       store_enable_n,
   input wire logic       program_strobe,
   input wire logic       vpp_select,
   input wire logic       vpp_high,
   input wire logic       select_line_six,
   input wire logic       select_line_seven,
   input wire logic       mode_a,
   input wire logic       mode_b,
   input wire logic       mode_c,
   input wire logic [7:0] low_address_port,
   input wire logic [4:0] high_address_lines,
   input wire logic [7:0] data_port_o,
   input wire logic       data_port_oe
);
   logic [22:0] pins, pins_q;
   logic [12:0] addr;
   logic [7:0]  id_exp;
   logic [3:0]  calm_q;
   logic        base, rd_lv, ver, sig, prg, settled;
   assign addr = {high_address_lines, low_address_port};
   assign pins = {reset_pin, store_enable_n, program_strobe, vpp_select, vpp_high, mode_a,
                  mode_b, mode_c, select_line_six, select_line_seven, addr};
   assign base = reset_pin && !store_enable_n && !select_line_six;
   assign rd_lv = base && program_strobe && vpp_select && !vpp_high && !mode_a;
   assign ver = rd_lv && mode_b && mode_c;
   assign sig = rd_lv && !mode_b && !mode_c;
   assign prg = base && select_line_seven && mode_a && mode_c && vpp_high;
   assign settled = calm_q >= 4'h8 && pins == pins_q;
   assign id_exp = addr == 13'h0030 ? ID_BYTE0 : addr == 13'h0031 ? ID_BYTE1 :
                   addr == 13'h0060 ? ID_BYTE2 : addr == 13'h0061 ? ID_REV : 8'hff;
   // edges since any pin last moved, saturating
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pins_q <= '0;
         calm_q <= '0;
      end
      else
      begin
         pins_q <= pins;
         calm_q <= (pins != pins_q) ? 4'h0 : calm_q + {3'h0, calm_q != 4'hf};
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_sel7_up;
      ver && $rose(select_line_seven) && data_port_oe;
   endsequence
   AST_BUS_OKAY: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
   AST_SIG_BYTES: assert property (sig && settled && !select_line_seven |->
      data_port_oe && data_port_o == id_exp) else $error("id byte wrong");
   AST_VERIFY_OE: assert property (ver && settled |-> data_port_oe == !select_line_seven)
      else $error("verify drive wrong");
   AST_PROG_QUIET: assert property (prg && settled |-> !data_port_oe)
      else $error("driving in program mode");
   AST_IDLE_QUIET: assert property (store_enable_n && settled |-> !data_port_oe)
      else $error("driving while deselected");
   AST_READ_ONLY: assert property (settled && data_port_oe |-> rd_lv)
      else $error("driving outside read modes");
   AST_OE_RISE: assert property ($rose(data_port_oe) |->
      !select_line_seven && !$past(select_line_seven, 3)) else $error("early drive");
   AST_OE_RELEASE: assert property (s_sel7_up |-> data_port_oe[*2] ##[1:8] !data_port_oe)
      else $error("drive not released");
endmodule
bind epl_eprom_lock epl_chk #(.ID_BYTE0(ID_BYTE0), .ID_BYTE1(ID_BYTE1), .ID_BYTE2(ID_BYTE2),
   .ID_REV(ID_REV)) epl_chk_inst (.hclk, .hresetn, .hreadyout, .hresp, .reset_pin,
   .store_enable_n, .program_strobe, .vpp_select, .vpp_high, .select_line_six,
   .select_line_seven, .mode_a, .mode_b, .mode_c, .low_address_port, .high_address_lines,
   .data_port_o, .data_port_oe);
`default_nettype wire

// [dv/epl_pgm.sv]
// programmer model driving the store block's programming pins
// assumes the bench resolves the shared data lines from both enables
`timescale 1ns/1ps
`default_nettype none
module epl_pgm
(
   // clock
   input wire logic         hclk,
   // control levels and address
   output logic             reset_pin,
   output logic             store_enable_n,
   output logic             program_strobe,
   output logic             vpp_select,
   output logic             vpp_high,
   output logic             select_line_six,
   output logic             select_line_seven,
   output logic             mode_a,
   output logic             mode_b,
   output logic             mode_c,
   output logic      [12:0] byte_address,
   // data lines
   input wire logic  [7:0]  dbus,
   output logic      [7:0]  d_o,
   output logic             d_oe
);
   int hold = 6;
   task automatic wt(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // modes: 0 idle, 1 program code, 2 program key, 3 verify, 4 signature
   task automatic lv(input int m);
      {reset_pin, store_enable_n, select_line_six, select_line_seven, program_strobe,
       vpp_select, vpp_high, mode_a, mode_b, mode_c} <=
         {1'b1, m == 0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, m < 3, m == 1 || m == 3, m != 4};
   endtask
   initial
   begin
      lv(0);
      byte_address <= '0;
      d_o          <= '0;
      d_oe         <= 1'b0;
   end
   task automatic prog(input int m, input logic [12:0] a, input logic [7:0] d);
      byte_address <= a;
      wt(hold);
      d_o  <= d;
      d_oe <= 1'b1;
      wt(hold);
      lv(m);
      wt(hold);
      vpp_high <= 1'b1;
      wt(hold);
      repeat (5)
      begin
         program_strobe <= 1'b0;
         wt(hold);
         program_strobe <= 1'b1;
         wt(hold);
      end
   endtask
   task automatic rd(input int m, input logic [12:0] a, output logic [7:0] q);
      d_oe <= 1'b0;
      lv(m);
      wt(hold);
      byte_address <= a;
      wt(hold);
      select_line_seven <= 1'b0;
      wt(2 * hold);
      q = dbus;
      select_line_seven <= 1'b1;
      wt(hold);
   endtask
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// top bench: ahb register tasks and programmer calls with expected values
// assumes the checker binds itself to the block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // arbitrary identification values
   localparam logic [31:0] IDS = 32'h4e5a6907;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, data_port_oe, d_oe;
   logic        reset_pin, store_enable_n, program_strobe, vpp_select, vpp_high;
   logic        select_line_six, select_line_seven, mode_a, mode_b, mode_c;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [12:0] byte_address;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [7:0]  data_port_o, d_o, dbus;
   logic [12:0] sa [5] = '{13'h30, 13'h31, 13'h60, 13'h61, 13'h32};
   logic [7:0]  se [5] = '{IDS[31:24], IDS[23:16], IDS[15:8], IDS[7:0], 8'hff};
   int          n_errors = 0;
   int          total_checks = 0;
   assign dbus = data_port_oe ? data_port_o : (d_oe ? d_o : ~d_o);
   epl_eprom_lock #(.ID_BYTE0(IDS[31:24]), .ID_BYTE1(IDS[23:16]), .ID_BYTE2(IDS[15:8]),
      .ID_REV(IDS[7:0])) epl_eprom_lock_inst (.*, .hready(hreadyout),
      .low_address_port(byte_address[7:0]), .high_address_lines(byte_address[12:8]),
      .data_port_i(dbus));
   epl_pgm epl_pgm_inst (.*);
   initial
   begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   task automatic print_verdict;
      if (n_errors == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", w, e, s);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic vr(input string w, input int m, input logic [12:0] a, input logic [7:0] e);
      logic [7:0] q;
      epl_pgm_inst.rd(m, a, q);
      chk(w, {24'h0, q}, {24'h0, e});
   endtask
   task automatic sts(input string w, input logic [31:0] e);
      bus(0, epl_pkg::REG_STATUS, 0, r);
      chk(w, r, e);
   endtask
   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      haddr = '0;
      hwdata = '0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(0, epl_pkg::REG_CTRL, 0, r);
      chk("ctrl", r, 32'h2);
      bus(1, epl_pkg::REG_STATUS, 32'hff, r);
      sts("status", 32'h0);
      bus(0, epl_pkg::REG_REV, 0, r);
      chk("rev", r, {24'h0, IDS[7:0]});
      bus(0, 8'h10, 0, r);
      chk("unmapped", r, 32'h0);
      vr("blank", 3, 13'h1fff, 8'hff);
      sts("verify mode", 32'h3);
      epl_pgm_inst.prog(1, 13'h0100, 8'ha5);
      sts("code pulses", 32'hd1);
      bus(0, epl_pkg::REG_LAST, 0, r);
      chk("last", r, {11'h0, 8'ha5, 13'h0100});
      vr("plain", 3, 13'h0100, 8'ha5);
      epl_pgm_inst.prog(2, 13'h0005, 8'h3c);
      sts("key pulses", 32'hd2);
      bus(0, epl_pkg::REG_LAST, 0, r);
      chk("last key", r, {11'h0, 8'hff, 13'h0005});
      epl_pgm_inst.hold = 10;
      epl_pgm_inst.prog(1, 13'h0045, 8'h0f);
      epl_pgm_inst.hold = 6;
      vr("cipher", 3, 13'h0045, 8'hcc);
      vr("other row", 3, 13'h0100, 8'ha5);
      vr("exposed", 3, 13'h1fc5, 8'h3c);
      for (int i = 0; i < 5; i++)
         vr("signature", 4, sa[i], se[i]);
      sts("sig mode", 32'h4);
      epl_pgm_inst.lv(0);
      bus(1, epl_pkg::REG_CTRL, 32'h0, r);
      epl_pgm_inst.prog(1, 13'h0200, 8'h00);
      bus(1, epl_pkg::REG_CTRL, 32'h2, r);
      vr("pins off", 3, 13'h0200, 8'hff);
      bus(1, epl_pkg::REG_CTRL, 32'h3, r);
      bus(0, epl_pkg::REG_CTRL, 0, r);
      chk("erase bit", r, 32'h2);
      vr("erased code", 3, 13'h0100, 8'hff);
      vr("erased key", 3, 13'h1fc5, 8'hff);
      print_verdict;
   end
   initial
   begin
      #200000;
      n_errors++;
      print_verdict;
   end
endmodule
`default_nettype wire
